// ---- src/bsq_defs.svh ----
// Constants for the buck start-up and over-voltage sequencer.
// Assumes a 10 MHz controller clock; included by the package users.
`ifndef BSQ_DEFS_SVH
`define BSQ_DEFS_SVH

// Register byte offsets.
`define BSQ_OFF_DELAY1 8'h00
`define BSQ_OFF_DELAY2 8'h04
`define BSQ_OFF_STATUS 8'h08
`define BSQ_OFF_IRQ_STAT 8'h0C
`define BSQ_OFF_IRQ_EN 8'h10
`define BSQ_OFF_IRQ_CLR 8'h14

// Reset values.
`define BSQ_RST_DELAY 16'h0000
`define BSQ_RST_IRQ_EN 8'h00

// Field positions.
`define BSQ_STAT_MEM_BIT 16
`define BSQ_EV_PG_RISE 0
`define BSQ_EV_OV1 1
`define BSQ_EV_OV2 2
`define BSQ_EV_HICCUP 3

// Timing.
`define BSQ_CLK_NS 100
`define BSQ_T_DEB_NS 1000
`define BSQ_T_NEG_OFF_NS 50
`define BSQ_DEB_CYC (`BSQ_T_DEB_NS / `BSQ_CLK_NS)
`define BSQ_NEG_OFF_CYC \
    ((`BSQ_T_NEG_OFF_NS + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS)

`endif

// ---- src/bsq_pkg.sv ----
// Types for the buck start-up and over-voltage sequencer.
// Assumes nothing of its surroundings.
package bsq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_RST_WAIT,
        ST_DELAY,
        ST_SOFTSTART,
        ST_GOOD_WAIT,
        ST_RUN,
        ST_HICCUP
    } bsq_state_t;
endpackage

// ---- src/bsq_sequencer.sv ----
// Two-channel start-up sequencer with recoverable over-voltage handling.
// Assumes comparator results and straps arrive asynchronously on pins,
// switch requests come from a modulator on clk, and APB on clk.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "bsq_defs.svh"

module bsq_sequencer #(
    parameter logic [15:0] RST_WAIT_CYC = 16'h03E8,
    parameter logic [15:0] GOOD_DELAY_CYC = 16'h2710,
    parameter logic [15:0] HICCUP_CYC = 16'h4E20
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous pins and comparators
    input wire logic [1:0] channel_enable,
    input wire logic internal_supply_good,
    input wire logic stage_ready_in,
    input wire logic delay2_memmode_select,
    input wire logic [1:0] softstart_done,
    input wire logic [1:0] hiccup_request,
    input wire logic [1:0] ov1_cmp,
    input wire logic [1:0] ov2_cmp,
    input wire logic [1:0] ov_clear_cmp,
    input wire logic [1:0] neg_ilim_cmp,
    // Modulator requests on clk
    input wire logic [1:0] pwm_hs_req,
    input wire logic [1:0] pwm_ls_req,
    // Power stage and status outputs
    output logic [1:0] hs_on,
    output logic [1:0] ls_on,
    output logic [1:0] ramp_enable,
    output logic [1:0] output_good_flag,
    output logic [1:0] overvolt_level_one,
    output logic [1:0] overvolt_level_two,
    output logic memory_mode,
    output logic irq
);
    localparam int NS = 17;
    // The strap bit resets to its idle high level, so that memory mode is
    // not latched by mistake in the two cycles after reset.
    localparam logic [NS-1:0] SY_RST = 17'h00001;

    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        if (a[31:8] != 24'h000000) begin
            reg_sel = 3'h7;
        end else begin
            case (a[7:0])
                `BSQ_OFF_DELAY1: reg_sel = 3'h0;
                `BSQ_OFF_DELAY2: reg_sel = 3'h1;
                `BSQ_OFF_STATUS: reg_sel = 3'h2;
                `BSQ_OFF_IRQ_STAT: reg_sel = 3'h3;
                `BSQ_OFF_IRQ_EN: reg_sel = 3'h4;
                `BSQ_OFF_IRQ_CLR: reg_sel = 3'h5;
                default: reg_sel = 3'h7;
            endcase
        end
    endfunction

    // Two-flop synchronisers; only the second stage is read.
    logic [NS-1:0] sy1_reg, sy2_reg, sy_raw;
    assign sy_raw = {neg_ilim_cmp, ov_clear_cmp, ov2_cmp, ov1_cmp,
                     hiccup_request, softstart_done, channel_enable,
                     internal_supply_good, stage_ready_in,
                     delay2_memmode_select};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sy1_reg <= SY_RST;
            sy2_reg <= SY_RST;
        end else if (ce) begin
            sy1_reg <= sy_raw;
            sy2_reg <= sy1_reg;
        end
    end

    logic s_msel, s_stage, s_supply;
    logic [1:0] s_en, s_ssd, s_hic, s_ov1, s_ov2, s_clr, s_neg;
    assign s_msel = sy2_reg[0];
    assign s_stage = sy2_reg[1];
    assign s_supply = sy2_reg[2];
    assign s_en = sy2_reg[4:3];
    assign s_ssd = sy2_reg[6:5];
    assign s_hic = sy2_reg[8:7];
    assign s_ov1 = sy2_reg[10:9];
    assign s_ov2 = sy2_reg[12:11];
    assign s_clr = sy2_reg[14:13];
    assign s_neg = sy2_reg[16:15];

    // Register file and memory mode latch.
    logic [15:0] dly_reg [2];
    logic [15:0] dly_next [2];
    logic [7:0] irq_en_reg, irq_en_next, irq_st_reg, irq_st_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic irq_reg, irq_next, mem_reg, mem_next;
    logic [7:0] ev_w;
    logic [15:0] stat_w;
    logic [1:0] off_w;
    logic acc, wr;
    logic [2:0] sel;

    always_comb begin
        acc = psel & penable;
        wr = acc & pready_reg & pwrite;
        sel = reg_sel(paddr);
        dly_next[0] = dly_reg[0];
        dly_next[1] = dly_reg[1];
        irq_en_next = irq_en_reg;
        pready_next = acc & ~pready_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (acc & ~pready_reg) begin
            pslverr_next = (reg_sel(paddr) == 3'h7);
            case (reg_sel(paddr))
                3'h0: prdata_next = {16'h0000, dly_reg[0]};
                3'h1: prdata_next = {16'h0000, dly_reg[1]};
                3'h2: prdata_next = {15'h0000, mem_reg, stat_w};
                3'h3: prdata_next = {24'h000000, irq_st_reg};
                3'h4: prdata_next = {24'h000000, irq_en_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (wr && sel == 3'h0) begin
            dly_next[0] = pwdata[15:0];
        end
        if (wr && sel == 3'h1) begin
            dly_next[1] = pwdata[15:0];
        end
        if (wr && sel == 3'h4) begin
            irq_en_next = pwdata[7:0];
        end
        // A new event outranks a clear written in the same cycle.
        irq_st_next = irq_st_reg | ev_w;
        if (wr && sel == 3'h5) begin
            irq_st_next = (irq_st_reg & ~pwdata[7:0]) | ev_w;
        end
        irq_next = |(irq_st_next & irq_en_next);
        // The strap is only looked at while nothing is starting.
        mem_next = (&off_w) ? ~s_msel : mem_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dly_reg[0] <= `BSQ_RST_DELAY;
            dly_reg[1] <= `BSQ_RST_DELAY;
            irq_en_reg <= `BSQ_RST_IRQ_EN;
            irq_st_reg <= 8'h00;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            mem_reg <= 1'b0;
        end else if (ce) begin
            dly_reg[0] <= dly_next[0];
            dly_reg[1] <= dly_next[1];
            irq_en_reg <= irq_en_next;
            irq_st_reg <= irq_st_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            mem_reg <= mem_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign memory_mode = mem_reg;

    // In memory mode a hiccup request from either side hits both.
    logic [1:0] hic_w;
    assign hic_w = mem_reg ? {2{|s_hic}} : s_hic;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        bsq_pkg::bsq_state_t st_reg, st_next;
        logic [15:0] tmr_reg, tmr_next, dly;
        logic [3:0] c1_reg, c1_next, c2_reg, c2_next;
        logic [1:0] nc_reg, nc_next;
        logic ov1_reg, ov1_next, ov2_reg, ov2_next;
        logic hs_reg, hs_next, ls_reg, ls_next, lsok_reg, lsok_next;
        logic pg_reg, pg_next, rmp_reg, rmp_next;
        logic go, arm1, arm2, trip1, trip2, live_next;

        always_comb begin
            go = s_en[i] & s_supply & s_stage;
            dly = mem_reg ? dly_reg[0] : dly_reg[i];
            arm2 = (st_reg == bsq_pkg::ST_SOFTSTART) ||
                   (st_reg == bsq_pkg::ST_GOOD_WAIT) ||
                   (st_reg == bsq_pkg::ST_RUN);
            arm1 = (st_reg == bsq_pkg::ST_RUN);
            c1_next = !s_ov1[i] ? 4'h0 :
                      (c1_reg == 4'(`BSQ_DEB_CYC)) ? c1_reg : c1_reg + 4'h1;
            c2_next = !s_ov2[i] ? 4'h0 :
                      (c2_reg == 4'(`BSQ_DEB_CYC)) ? c2_reg : c2_reg + 4'h1;
            trip1 = s_ov1[i] && c1_reg == 4'(`BSQ_DEB_CYC);
            trip2 = s_ov2[i] && c2_reg == 4'(`BSQ_DEB_CYC);
            ov2_next = ov2_reg;
            ov1_next = ov1_reg;
            if (!arm2) begin
                ov2_next = 1'b0;
                ov1_next = 1'b0;
            end else if (trip2) begin
                ov2_next = 1'b1;
                ov1_next = 1'b0;
            end else if (arm1 && trip1 && !ov2_reg) begin
                ov1_next = 1'b1;
            end else if (s_clr[i]) begin
                ov2_next = 1'b0;
                ov1_next = 1'b0;
            end
            st_next = st_reg;
            tmr_next = tmr_reg;
            case (st_reg)
                bsq_pkg::ST_OFF: begin
                    tmr_next = 16'h0000;
                    if (go) begin
                        st_next = bsq_pkg::ST_RST_WAIT;
                    end
                end
                bsq_pkg::ST_RST_WAIT: begin
                    tmr_next = tmr_reg + 16'h0001;
                    if (tmr_reg >= RST_WAIT_CYC - 16'h0001) begin
                        st_next = bsq_pkg::ST_DELAY;
                        tmr_next = 16'h0000;
                    end
                end
                bsq_pkg::ST_DELAY: begin
                    tmr_next = tmr_reg + 16'h0001;
                    if (tmr_reg >= dly) begin
                        st_next = bsq_pkg::ST_SOFTSTART;
                        tmr_next = 16'h0000;
                    end
                end
                bsq_pkg::ST_SOFTSTART: begin
                    if (s_ssd[i]) begin
                        st_next = bsq_pkg::ST_GOOD_WAIT;
                        tmr_next = 16'h0000;
                    end
                end
                bsq_pkg::ST_GOOD_WAIT: begin
                    // The good delay restarts only once the fault is gone.
                    if (ov1_reg || ov2_reg) begin
                        tmr_next = 16'h0000;
                    end else if (tmr_reg >= GOOD_DELAY_CYC - 16'h0001) begin
                        st_next = bsq_pkg::ST_RUN;
                    end else begin
                        tmr_next = tmr_reg + 16'h0001;
                    end
                end
                bsq_pkg::ST_RUN: begin
                    if (ov1_next || ov2_next) begin
                        st_next = bsq_pkg::ST_GOOD_WAIT;
                        tmr_next = 16'h0000;
                    end
                end
                bsq_pkg::ST_HICCUP: begin
                    tmr_next = tmr_reg + 16'h0001;
                    if (tmr_reg >= HICCUP_CYC - 16'h0001) begin
                        st_next = bsq_pkg::ST_RST_WAIT;
                        tmr_next = 16'h0000;
                    end
                end
                default: begin
                    st_next = bsq_pkg::ST_OFF;
                    tmr_next = 16'h0000;
                end
            endcase
            if (arm2 && hic_w[i]) begin
                st_next = bsq_pkg::ST_HICCUP;
                tmr_next = 16'h0000;
            end
            if (!go) begin
                st_next = bsq_pkg::ST_OFF;
            end
            live_next = (st_next == bsq_pkg::ST_SOFTSTART) ||
                        (st_next == bsq_pkg::ST_GOOD_WAIT) ||
                        (st_next == bsq_pkg::ST_RUN);
            if (!live_next) begin
                ov1_next = 1'b0;
                ov2_next = 1'b0;
            end
            nc_next = 2'h0;
            if (ov1_next && s_neg[i]) begin
                nc_next = 2'(`BSQ_NEG_OFF_CYC);
            end else if (ov1_next && nc_reg != 2'h0) begin
                nc_next = nc_reg - 2'h1;
            end
            // Pre-biased output: no modulator low-side until switching has begun.
            lsok_next = live_next & (lsok_reg | pwm_hs_req[i]);
            hs_next = 1'b0;
            ls_next = 1'b0;
            if (ov2_next) begin
                ls_next = 1'b1;
            end else if (ov1_next) begin
                ls_next = ~s_neg[i] & (nc_reg == 2'h0);
            end else if (live_next) begin
                hs_next = pwm_hs_req[i];
                ls_next = pwm_ls_req[i] & lsok_next;
            end
            rmp_next = live_next;
            pg_next = (st_next == bsq_pkg::ST_RUN) &&
                      !ov1_next && !ov2_next;
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                st_reg <= bsq_pkg::ST_OFF;
                tmr_reg <= 16'h0000;
                c1_reg <= 4'h0;
                c2_reg <= 4'h0;
                nc_reg <= 2'h0;
                ov1_reg <= 1'b0;
                ov2_reg <= 1'b0;
                hs_reg <= 1'b0;
                ls_reg <= 1'b0;
                lsok_reg <= 1'b0;
                pg_reg <= 1'b0;
                rmp_reg <= 1'b0;
            end else if (ce) begin
                st_reg <= st_next;
                tmr_reg <= tmr_next;
                c1_reg <= c1_next;
                c2_reg <= c2_next;
                nc_reg <= nc_next;
                ov1_reg <= ov1_next;
                ov2_reg <= ov2_next;
                hs_reg <= hs_next;
                ls_reg <= ls_next;
                lsok_reg <= lsok_next;
                pg_reg <= pg_next;
                rmp_reg <= rmp_next;
            end
        end

        assign hs_on[i] = hs_reg;
        assign ls_on[i] = ls_reg;
        assign ramp_enable[i] = rmp_reg;
        assign output_good_flag[i] = pg_reg;
        assign overvolt_level_one[i] = ov1_reg;
        assign overvolt_level_two[i] = ov2_reg;
        assign off_w[i] = (st_reg == bsq_pkg::ST_OFF);
        assign stat_w[i*8 +: 8] = {2'h0, pg_reg, ov2_reg, ov1_reg,
                                   3'(st_reg)};
        assign ev_w[i*4 + `BSQ_EV_PG_RISE] = ce & pg_next & ~pg_reg;
        assign ev_w[i*4 + `BSQ_EV_OV1] = ce & ov1_next & ~ov1_reg;
        assign ev_w[i*4 + `BSQ_EV_OV2] = ce & ov2_next & ~ov2_reg;
        assign ev_w[i*4 + `BSQ_EV_HICCUP] = ce &
            (st_next == bsq_pkg::ST_HICCUP) & (st_reg != bsq_pkg::ST_HICCUP);
    end
endmodule

// ---- test/bsq_seq_monitor.sv ----
// Concurrent checks on channel one of the start-up sequencer.
// Assumes binding into bsq_sequencer with ce held high.
`timescale 1ns/1ps
module bsq_seq_monitor #(
    parameter logic [15:0] RST_WAIT_CYC = 16'h03E8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins watched
    input wire logic [1:0] channel_enable,
    input wire logic internal_supply_good,
    input wire logic stage_ready_in,
    input wire logic [1:0] ov1_cmp,
    input wire logic [1:0] ov2_cmp,
    input wire logic [1:0] ov_clear_cmp,
    input wire logic [1:0] neg_ilim_cmp,
    // Outputs watched
    input wire logic [1:0] hs_on,
    input wire logic [1:0] ls_on,
    input wire logic [1:0] ramp_enable,
    input wire logic [1:0] output_good_flag,
    input wire logic [1:0] overvolt_level_one,
    input wire logic [1:0] overvolt_level_two,
    input wire logic memory_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] go_cnt;
    logic [3:0] ov_cnt;
    logic seen;
    logic ov;
    logic go;
    assign ov = overvolt_level_one[0] | overvolt_level_two[0];
    assign go = channel_enable[0] & internal_supply_good & stage_ready_in;
    // Counters saturate so a long run never wraps into a false pass.
    always_ff @(posedge clk) begin
        go_cnt <= !go ? 16'h0000 : go_cnt + 16'(go_cnt != 16'hFFFF);
        ov_cnt <= !ov1_cmp[0] ? 4'h0 : ov_cnt + 4'(ov_cnt != 4'hF);
        seen <= rst_n && ramp_enable[0] && (seen || hs_on[0]);
    end
    sequence clr_held;
        ov ##0 (ov_clear_cmp[0] && !ov1_cmp[0] && !ov2_cmp[0]) [*5];
    endsequence
    start_after_wait_a: assert property ($rose(ramp_enable[0]) |->
        go_cnt > RST_WAIT_CYC) else $error("ramp before reset wait");
    prebias_ls_off_a: assert property (ramp_enable[0] && !seen &&
        !ov |-> !ls_on[0]) else $error("low side before high side");
    enable_loss_a: assert property (!channel_enable[0] [*4] |->
        !ramp_enable[0]) else $error("ramp while disabled");
    ov_debounce_a: assert property ($rose(overvolt_level_one[0]) |->
        $past(ov_cnt, 2) >= 4'hB) else $error("level one too early");
    ov_switch_safe_a: assert property (ov && $past(ov) |->
        !hs_on[0] && !output_good_flag[0]) else $error("unsafe in ov");
    ov2_ls_hold_a: assert property (overvolt_level_two[0] &&
        $past(overvolt_level_two[0]) |-> ls_on[0]) else $error("ls off");
    neg_ls_off_a: assert property (overvolt_level_one[0] &&
        !overvolt_level_two[0] && $past(overvolt_level_one[0], 4) &&
        $past(neg_ilim_cmp[0], 3) |-> !ls_on[0]) else $error("ls kept");
    ov1_arming_a: assert property ($rose(overvolt_level_one[0]) |->
        $past(output_good_flag[0])) else $error("level one unarmed");
    ov2_arming_a: assert property ($rose(overvolt_level_two[0]) |->
        $past(ramp_enable[0])) else $error("level two unarmed");
    ov_clear_a: assert property (clr_held |=> !ov &&
        ramp_enable[0]) else $error("ov not cleared");
    pair_mode_a: assert property (memory_mode && $past(memory_mode) |->
        ramp_enable[0] == ramp_enable[1]) else $error("channels apart");
endmodule
bind bsq_sequencer bsq_seq_monitor #(.RST_WAIT_CYC(RST_WAIT_CYC)) i_mon (
    .clk(clk), .rst_n(rst_n), .channel_enable(channel_enable),
    .internal_supply_good(internal_supply_good),
    .stage_ready_in(stage_ready_in), .ov1_cmp(ov1_cmp), .ov2_cmp(ov2_cmp),
    .ov_clear_cmp(ov_clear_cmp), .neg_ilim_cmp(neg_ilim_cmp),
    .hs_on(hs_on), .ls_on(ls_on), .ramp_enable(ramp_enable),
    .output_good_flag(output_good_flag),
    .overvolt_level_one(overvolt_level_one),
    .overvolt_level_two(overvolt_level_two), .memory_mode(memory_mode));

// ---- test/bsq_stage_model.sv ----
// Power stage and modulator model for both channels.
// Assumes ramp_enable from the sequencer; answers on clk.
`timescale 1ns/1ps
module bsq_stage_model #(
    parameter int SS_CYC = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // From the sequencer
    input wire logic [1:0] ramp_enable,
    // To the sequencer
    output logic stage_ready_in = 1'b0,
    output logic [1:0] softstart_done = 2'h0,
    output logic [1:0] pwm_hs_req = 2'h0,
    output logic [1:0] pwm_ls_req = 2'h0
);
    int ss_cnt [2] = '{0, 0};
    logic [1:0] ph = 2'h0;
    // Low-side requests can come before the first high-side one.
    always @(posedge clk) begin
        stage_ready_in <= rst_n;
        ph <= rst_n ? ph + 2'h1 : 2'h0;
        for (int i = 0; i < 2; i++) begin
            ss_cnt[i] <= ramp_enable[i] ? ss_cnt[i] + 1 : 0;
            softstart_done[i] <= ramp_enable[i] && ss_cnt[i] >= SS_CYC;
            pwm_hs_req[i] <= ramp_enable[i] && ph == 2'h0;
            pwm_ls_req[i] <= ramp_enable[i] && ph[1];
        end
    end
endmodule

// ---- test/bsq_sequencer_bench.sv ----
// Self-checking bench for the two-channel start-up sequencer.
// Assumes the stage model answers soft start and modulator requests.
`timescale 1ns/1ps
module bsq_sequencer_bench;
    localparam int RW = 8;
    localparam int GD = 16;
    localparam int HC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] en = 2'h0, hic = 2'h0, ov1 = 2'h0, ov2 = 2'h0;
    logic [1:0] clr = 2'h0, neg = 2'h0;
    logic sup = 1'b0;
    logic strap = 1'b1;
    logic [31:0] prdata, r;
    logic pready, pslverr, stage, mem, irq, e;
    logic [1:0] ssd, hs_r, ls_r, hs, ls, ramp, good, l1, l2;
    logic [31:0] x = 32'h51;
    logic [15:0] d1, d2;
    int mismatches = 0;
    int checks = 0;
    int a, b, n;
    bsq_sequencer #(.RST_WAIT_CYC(16'h8), .GOOD_DELAY_CYC(16'h10),
        .HICCUP_CYC(16'h14)) i_bsq_sequencer (.clk(clk), .rst_n(rst_n),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .channel_enable(en), .internal_supply_good(sup),
        .stage_ready_in(stage), .delay2_memmode_select(strap),
        .softstart_done(ssd), .hiccup_request(hic), .ov1_cmp(ov1),
        .ov2_cmp(ov2), .ov_clear_cmp(clr), .neg_ilim_cmp(neg),
        .pwm_hs_req(hs_r), .pwm_ls_req(ls_r), .hs_on(hs), .ls_on(ls),
        .ramp_enable(ramp), .output_good_flag(good),
        .overvolt_level_one(l1), .overvolt_level_two(l2),
        .memory_mode(mem), .irq(irq));
    bsq_stage_model i_bsq_stage_model (.clk(clk), .rst_n(rst_n),
        .ramp_enable(ramp), .stage_ready_in(stage), .softstart_done(ssd),
        .pwm_hs_req(hs_r), .pwm_ls_req(ls_r));
    always #50 clk = ~clk;
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // Start takes reset wait plus delay plus one; sync adds a few cycles.
    function automatic logic win(int n, int lo);
        return n >= lo && n <= lo + 8;
    endfunction
    function automatic logic sig(int k);
        case (k)
            0: return good[0];
            1: return l1[0];
            2: return l2[0];
            3: return !(l1[0] | l2[0]);
            default: return !ramp[1];
        endcase
    endfunction
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] ad, dt);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(k < 20, "apb hang");
    endtask
    task automatic wfor(input int k, input int max);
        n = 0;
        while (sig(k) !== 1'b1 && n < max) begin
            @(posedge clk);
            n++;
        end
        chk(n < max, "wait ran out");
    endtask
    task automatic ramps();
        a = -1;
        b = -1;
        for (int k = 0; k < 400 && (a < 0 || b < 0); k++) begin
            @(posedge clk);
            if (ramp[0] === 1'b1 && a < 0) a = k;
            if (ramp[1] === 1'b1 && b < 0) b = k;
        end
    endtask
    initial begin
        #(100 * 6000);
        mismatches++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, 32'h0, 32'h0);
        chk(r === 32'h0 && e === 1'b0, "delay reset");
        apb(0, 32'h10, 32'h0);
        chk(r === 32'h0, "irq enable reset");
        apb(1, 32'h40, 32'h5);
        chk(e === 1'b1, "unmapped write");
        d1 = 16'(1 + rnd() % 8);
        d2 = d1 + 16'(6 + rnd() % 4);
        apb(1, 32'h0, {16'h0, d1});
        apb(1, 32'h4, {16'h0, d2});
        apb(1, 32'h10, 32'h1);
        en <= 2'h3;
        repeat (30) @(posedge clk);
        chk(ramp === 2'h0, "ramp without supply");
        sup <= 1'b1;
        ramps();
        chk(win(a, RW + d1 + 1) && win(b, RW + d2 + 1), "delay");
        chk(mem === 1'b0, "strap high");
        wfor(0, 60);
        repeat (30) @(posedge clk);
        chk(irq === 1'b1, "irq not raised");
        apb(1, 32'h14, 32'h1);
        repeat (3) @(posedge clk);
        apb(0, 32'hC, 32'h0);
        chk(r[4:0] === 5'h10 && irq === 1'b0, "irq mask or clear");
        apb(1, 32'h14, 32'h10);
        ov1 <= 2'h1;
        repeat (6) @(posedge clk);
        ov1 <= 2'h0;
        repeat (6) @(posedge clk);
        chk(l1[0] === 1'b0, "glitch taken");
        ov1 <= 2'h1;
        wfor(1, 20);
        repeat (2) @(posedge clk);
        chk(good[0] === 1'b0 && hs[0] === 1'b0, "level one");
        neg <= 2'h1;
        repeat (3) @(posedge clk);
        neg <= 2'h0;
        ov2 <= 2'h1;
        wfor(2, 20);
        neg <= 2'h1;
        repeat (4) @(posedge clk);
        chk(ls[0] === 1'b1 && hs[0] === 1'b0, "level two");
        neg <= 2'h0;
        ov1 <= 2'h0;
        ov2 <= 2'h0;
        clr <= 2'h1;
        wfor(3, 20);
        repeat (4) @(posedge clk);
        clr <= 2'h0;
        chk(ramp[0] === 1'b1, "restarted");
        wfor(0, GD + 20);
        chk(n >= GD - 4, "good came back early");
        hic <= 2'h2;
        repeat (3) @(posedge clk);
        hic <= 2'h0;
        wfor(4, 10);
        ramps();
        chk(win(b, HC + RW + d2 - 1) && a == 0, "hiccup restart");
        en <= 2'h0;
        repeat (6) @(posedge clk);
        chk(ramp === 2'h0 && good === 2'h0, "disable");
        strap <= 1'b0;
        repeat (5) @(posedge clk);
        chk(mem === 1'b1, "pairing mode");
        apb(0, 32'h8, 32'h0);
        chk(r === 32'h00010000 && e === 1'b0, "status word");
        en <= 2'h3;
        ramps();
        chk(a == b && win(a, RW + d1 + 1), "shared delay");
        strap <= 1'b1;
        repeat (4) @(posedge clk);
        chk(mem === 1'b1, "strap not held");
        hic <= 2'h1;
        repeat (3) @(posedge clk);
        hic <= 2'h0;
        wfor(4, 10);
        chk(ramp[0] === 1'b0, "joint hiccup");
        results();
    end
endmodule
